// ---- minmax_capture_pkg.sv ----
package minmax_capture_pkg;
  typedef struct packed {
    logic        valid;
    logic [19:0] press;
    logic [11:0] temp;
  } sample_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// ---- minmax_capture_regs.svh ----
`ifndef MINMAX_CAPTURE_REGS_SVH
`define MINMAX_CAPTURE_REGS_SVH

`define ADDR_TEMP_ALARM_WINDOW    8'h18
`define ADDR_PRESS_WINDOW_BYTE_A  8'h19
`define ADDR_PRESS_WINDOW_BYTE_B  8'h1A
`define ADDR_LOWEST_PRESS_HIGH    8'h1C
`define ADDR_LOWEST_PRESS_MID     8'h1D
`define ADDR_LOWEST_PRESS_LOW     8'h1E
`define ADDR_LOWEST_TEMP_HIGH     8'h1F
`define ADDR_LOWEST_TEMP_LOW      8'h20
`define ADDR_HIGHEST_PRESS_HIGH   8'h21
`define ADDR_HIGHEST_PRESS_MID    8'h22
`define ADDR_HIGHEST_PRESS_LOW    8'h23
`define ADDR_MODE_CTRL            8'h26
`define MODE_ALT_BIT              7
`define RESET_BYTE                8'h00
`define FRAC_MASK                 8'hF0

`endif

// ---- minmax_capture_window_regs.sv ----
`timescale 1ns/1ps
`include "minmax_capture_regs.svh"

// Functional notes
// - pressure window: 16-bit unsigned, two RW bytes
// - window in meters (altitude) or 2 Pa
// - temperature window: unsigned 8-bit RW byte
// - three-byte lowest pressure/altitude capture
// - three-byte highest pressure/altitude capture
// - altitude capture: 20-bit signed meters
// - altitude: 16 integer bits, 4 fraction bits
// - pressure capture: 20-bit unsigned pascals
// - pressure: 18 integer bits incl. LSB 7:6
// - pressure fraction bits in LSB 5:4
// - captures cleared at reset or by writing zero
// - lowest temperature capture: 12-bit signed
// - temp: integer high byte, fraction low 7:4
// - mode bit: 0 barometric, 1 altitude
module minmax_capture_window_regs
  import minmax_capture_pkg::*;
(
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire minmax_capture_pkg::reg_req_t req_i,
  input  wire minmax_capture_pkg::sample_t  sample_i,
  output logic [7:0]                        rdata_o,
  output logic                              alt_mode_o,
  output logic [15:0]                       press_window_o,
  output logic [7:0]                        temp_window_o
);
  import minmax_capture_pkg::*;

  logic [7:0]  temp_win_q,  temp_win_d;
  logic [15:0] press_win_q, press_win_d;
  logic        alt_q,       alt_d;
  logic [19:0] pmin_q,      pmin_d;
  logic [19:0] pmax_q,      pmax_d;
  logic [11:0] tmin_q,      tmin_d;
  logic        pmin_ok_q,   pmin_ok_d;
  logic        pmax_ok_q,   pmax_ok_d;
  logic        tmin_ok_q,   tmin_ok_d;
  logic [7:0]  rdata_q,     rdata_d;

  // signed compare in altitude mode, unsigned in barometric mode
  function automatic logic press_less(input logic [19:0] a, input logic [19:0] b, input logic altitude_mode_select);
    if (altitude_mode_select) begin
      press_less = $signed(a) < $signed(b);
    end else begin
      press_less = a < b;
    end
  endfunction

  function automatic logic wr_hit(input reg_req_t r, input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  // a capture spans consecutive byte addresses
  function automatic logic wr_span(input reg_req_t r, input logic [7:0] lo, input logic [7:0] hi);
    wr_span = r.wr && (r.addr >= lo) && (r.addr <= hi);
  endfunction

  function automatic logic rd_hit(input reg_req_t r, input logic [7:0] a);
    rd_hit = r.rd && (r.addr == a);
  endfunction

  // window and mode group: plain byte registers, no side effects
  always_comb begin
    temp_win_d  = temp_win_q;
    press_win_d = press_win_q;
    alt_d       = alt_q;
    if (wr_hit(req_i, `ADDR_TEMP_ALARM_WINDOW)) begin
      temp_win_d = req_i.wdata;
    end
    // byte a carries the upper half, byte b the lower
    if (wr_hit(req_i, `ADDR_PRESS_WINDOW_BYTE_A)) begin
      press_win_d[15:8] = req_i.wdata;
    end
    if (wr_hit(req_i, `ADDR_PRESS_WINDOW_BYTE_B)) begin
      press_win_d[7:0] = req_i.wdata;
    end
    // mode relabels units and selects signed or unsigned capture compare; stored bits are never rescaled
    if (wr_hit(req_i, `ADDR_MODE_CTRL)) begin
      alt_d = req_i.wdata[`MODE_ALT_BIT];
    end
  end

  // capture group
  always_comb begin
    pmin_d      = pmin_q;
    pmax_d      = pmax_q;
    tmin_d      = tmin_q;
    pmin_ok_d   = pmin_ok_q;
    pmax_ok_d   = pmax_ok_q;
    tmin_ok_d   = tmin_ok_q;

    // hardware capture first; a host write in the same cycle overrides it
    if (sample_i.valid) begin
      if (!pmin_ok_q || press_less(sample_i.press, pmin_q, alt_q)) begin
        pmin_d    = sample_i.press;
        pmin_ok_d = 1'b1;
      end
      if (!pmax_ok_q || press_less(pmax_q, sample_i.press, alt_q)) begin
        pmax_d    = sample_i.press;
        pmax_ok_d = 1'b1;
      end
      if (!tmin_ok_q || $signed(sample_i.temp) < $signed(tmin_q)) begin
        tmin_d    = sample_i.temp;
        tmin_ok_d = 1'b1;
      end
    end

    // writes land in the byte; a write that leaves the whole capture zero re-arms first-sample load
    if (wr_hit(req_i, `ADDR_LOWEST_PRESS_HIGH)) begin
      pmin_d[19:12] = req_i.wdata;
    end
    if (wr_hit(req_i, `ADDR_LOWEST_PRESS_MID)) begin
      pmin_d[11:4] = req_i.wdata;
    end
    if (wr_hit(req_i, `ADDR_LOWEST_PRESS_LOW)) begin
      pmin_d[3:0] = req_i.wdata[7:4];
    end
    if (wr_hit(req_i, `ADDR_HIGHEST_PRESS_HIGH)) begin
      pmax_d[19:12] = req_i.wdata;
    end
    if (wr_hit(req_i, `ADDR_HIGHEST_PRESS_MID)) begin
      pmax_d[11:4] = req_i.wdata;
    end
    if (wr_hit(req_i, `ADDR_HIGHEST_PRESS_LOW)) begin
      pmax_d[3:0] = req_i.wdata[7:4];
    end
    if (wr_hit(req_i, `ADDR_LOWEST_TEMP_HIGH)) begin
      tmin_d[11:4] = req_i.wdata;
    end
    if (wr_hit(req_i, `ADDR_LOWEST_TEMP_LOW)) begin
      tmin_d[3:0] = req_i.wdata[7:4];
    end

    // only a write into the capture itself re-arms it, so a genuine
    // zero result survives writes to unrelated registers
    if (wr_span(req_i, `ADDR_LOWEST_PRESS_HIGH, `ADDR_LOWEST_PRESS_LOW) && pmin_d == 20'h00000) begin
      pmin_ok_d = 1'b0;
    end
    if (wr_span(req_i, `ADDR_HIGHEST_PRESS_HIGH, `ADDR_HIGHEST_PRESS_LOW) && pmax_d == 20'h00000) begin
      pmax_ok_d = 1'b0;
    end
    if (wr_span(req_i, `ADDR_LOWEST_TEMP_HIGH, `ADDR_LOWEST_TEMP_LOW) && tmin_d == 12'h000) begin
      tmin_ok_d = 1'b0;
    end
  end

  always_comb begin
    case (req_i.addr)
      `ADDR_TEMP_ALARM_WINDOW:   rdata_d = temp_win_q;
      `ADDR_PRESS_WINDOW_BYTE_A: rdata_d = press_win_q[15:8];
      `ADDR_PRESS_WINDOW_BYTE_B: rdata_d = press_win_q[7:0];
      `ADDR_LOWEST_PRESS_HIGH:   rdata_d = pmin_q[19:12];
      `ADDR_LOWEST_PRESS_MID:    rdata_d = pmin_q[11:4];
      `ADDR_LOWEST_PRESS_LOW:    rdata_d = {pmin_q[3:0], 4'h0};
      `ADDR_LOWEST_TEMP_HIGH:    rdata_d = tmin_q[11:4];
      `ADDR_LOWEST_TEMP_LOW:     rdata_d = {tmin_q[3:0], 4'h0};
      `ADDR_HIGHEST_PRESS_HIGH:  rdata_d = pmax_q[19:12];
      `ADDR_HIGHEST_PRESS_MID:   rdata_d = pmax_q[11:4];
      `ADDR_HIGHEST_PRESS_LOW:   rdata_d = {pmax_q[3:0], 4'h0};
      `ADDR_MODE_CTRL:           rdata_d = {alt_q, 7'h00};
      default:                   rdata_d = `RESET_BYTE;
    endcase
    if (!req_i.rd) begin
      rdata_d = rdata_q;
    end
  end

  // window and mode registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      temp_win_q  <= `RESET_BYTE;
      press_win_q <= 16'h0000;
      alt_q       <= 1'b0;
    end else begin
      temp_win_q  <= temp_win_d;
      press_win_q <= press_win_d;
      alt_q       <= alt_d;
    end
  end

  // capture registers and their armed flags
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pmin_q      <= 20'h00000;
      pmax_q      <= 20'h00000;
      tmin_q      <= 12'h000;
      pmin_ok_q   <= 1'b0;
      pmax_ok_q   <= 1'b0;
      tmin_ok_q   <= 1'b0;
    end else begin
      pmin_q      <= pmin_d;
      pmax_q      <= pmax_d;
      tmin_q      <= tmin_d;
      pmin_ok_q   <= pmin_ok_d;
      pmax_ok_q   <= pmax_ok_d;
      tmin_ok_q   <= tmin_ok_d;
    end
  end

  // read data register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= `RESET_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o        = rdata_q;
  assign alt_mode_o     = alt_q;
  assign press_window_o = press_win_q;
  assign temp_window_o  = temp_win_q;

  a_min_first_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (sample_i.valid && !pmin_ok_q && !req_i.wr) |=> (pmin_q == $past(sample_i.press) && pmin_ok_q))
    else $error("first sample not loaded into minimum");

  a_max_monotone: assert property (@(posedge clk_i) disable iff (rst_i)
    (pmax_ok_q && !req_i.wr && !$changed(alt_q)) |=> !press_less(pmax_q, $past(pmax_q), alt_q))
    else $error("maximum capture decreased");

  a_min_monotone: assert property (@(posedge clk_i) disable iff (rst_i)
    (pmin_ok_q && !req_i.wr && !$changed(alt_q)) |=> !press_less($past(pmin_q), pmin_q, alt_q))
    else $error("minimum capture increased");

  a_tmin_monotone: assert property (@(posedge clk_i) disable iff (rst_i)
    (tmin_ok_q && !req_i.wr) |=> ($signed(tmin_q) <= $signed($past(tmin_q))))
    else $error("temperature minimum increased");

  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.rd && (req_i.addr == `ADDR_LOWEST_PRESS_LOW || req_i.addr == `ADDR_HIGHEST_PRESS_LOW
      || req_i.addr == `ADDR_LOWEST_TEMP_LOW)) |=> (rdata_o[3:0] == 4'h0))
    else $error("reserved capture bits read nonzero");

  a_window_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.wr && req_i.addr == `ADDR_PRESS_WINDOW_BYTE_A) |=> (press_window_o[15:8] == $past(req_i.wdata)))
    else $error("window upper byte not written");

  a_temp_window: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.wr && req_i.addr == `ADDR_TEMP_ALARM_WINDOW) |=> (temp_window_o == $past(req_i.wdata)))
    else $error("temperature window lost");

  a_mode_select: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.wr && req_i.addr == `ADDR_MODE_CTRL) |=> (alt_mode_o == $past(req_i.wdata[`MODE_ALT_BIT])))
    else $error("mode bit not taken");

  a_clear_rearms: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.wr && req_i.addr == `ADDR_LOWEST_TEMP_HIGH && req_i.wdata == 8'h00 && tmin_q[3:0] == 4'h0
      && !sample_i.valid) |=> !tmin_ok_q)
    else $error("zero write did not clear temperature minimum");

  a_max_clear_rearms: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_hit(req_i, `ADDR_HIGHEST_PRESS_HIGH) && req_i.wdata == 8'h00 && pmax_q[11:0] == 12'h000
      && !sample_i.valid) |=> !pmax_ok_q)
    else $error("zero write did not clear maximum");

  a_reset_clear: assert property (@(posedge clk_i)
    rst_i |=> (pmin_q == 20'h00000 && pmax_q == 20'h00000 && tmin_q == 12'h000 && !alt_mode_o
      && rdata_o == 8'h00))
    else $error("state not cleared by reset");

  a_window_low_byte: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hit(req_i, `ADDR_PRESS_WINDOW_BYTE_B) |=> (press_window_o[7:0] == $past(req_i.wdata)))
    else $error("window lower byte not written");

  a_window_high_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_hit(req_i, `ADDR_PRESS_WINDOW_BYTE_A) |=> (rdata_o == $past(press_win_q[15:8])))
    else $error("window upper byte read wrong");

  a_window_units_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hit(req_i, `ADDR_MODE_CTRL) |=> ($stable(press_window_o) && $stable(temp_window_o)))
    else $error("mode change altered a window value");

  a_temp_window_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_hit(req_i, `ADDR_TEMP_ALARM_WINDOW) |=> (rdata_o == $past(temp_win_q)))
    else $error("temperature window read wrong");

  a_min_mid_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_hit(req_i, `ADDR_LOWEST_PRESS_MID) |=> (rdata_o == $past(pmin_q[11:4])))
    else $error("minimum middle byte read wrong");

  a_max_high_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_hit(req_i, `ADDR_HIGHEST_PRESS_HIGH) |=> (rdata_o == $past(pmax_q[19:12])))
    else $error("maximum high byte read wrong");

  a_alt_min_signed: assert property (@(posedge clk_i) disable iff (rst_i)
    (sample_i.valid && pmin_ok_q && alt_q && !req_i.wr && $signed(sample_i.press) < $signed(pmin_q))
      |=> (pmin_q == $past(sample_i.press)))
    else $error("signed altitude minimum not captured");

  a_min_high_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_hit(req_i, `ADDR_LOWEST_PRESS_HIGH) |=> (rdata_o == $past(pmin_q[19:12])))
    else $error("minimum high byte read wrong");

  a_baro_max_unsigned: assert property (@(posedge clk_i) disable iff (rst_i)
    (sample_i.valid && pmax_ok_q && !alt_q && !req_i.wr && sample_i.press > pmax_q)
      |=> (pmax_q == $past(sample_i.press)))
    else $error("unsigned pressure maximum not captured");

  a_max_mid_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_hit(req_i, `ADDR_HIGHEST_PRESS_MID) |=> (rdata_o == $past(pmax_q[11:4])))
    else $error("maximum middle byte read wrong");

  a_max_frac_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_hit(req_i, `ADDR_HIGHEST_PRESS_LOW) |=> (rdata_o[7:4] == $past(pmax_q[3:0])))
    else $error("maximum fraction bits read wrong");

  a_min_frac_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_hit(req_i, `ADDR_LOWEST_PRESS_LOW) |=> (rdata_o[7:4] == $past(pmin_q[3:0])))
    else $error("minimum fraction bits read wrong");

  a_tmin_signed: assert property (@(posedge clk_i) disable iff (rst_i)
    (sample_i.valid && tmin_ok_q && !req_i.wr && $signed(sample_i.temp) < $signed(tmin_q))
      |=> (tmin_q == $past(sample_i.temp)))
    else $error("lower temperature not captured");

  a_tmin_high_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_hit(req_i, `ADDR_LOWEST_TEMP_HIGH) |=> (rdata_o == $past(tmin_q[11:4])))
    else $error("temperature minimum high byte read wrong");

  a_tmin_low_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_hit(req_i, `ADDR_LOWEST_TEMP_LOW) |=> (rdata_o[7:4] == $past(tmin_q[3:0])))
    else $error("temperature fraction bits read wrong");

  a_mode_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_hit(req_i, `ADDR_MODE_CTRL) |=> (rdata_o == {$past(alt_q), 7'h00}))
    else $error("mode bit read wrong");

  a_max_first_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (sample_i.valid && !pmax_ok_q && !req_i.wr) |=> (pmax_q == $past(sample_i.press) && pmax_ok_q))
    else $error("first sample not loaded into maximum");

  a_tmin_first_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (sample_i.valid && !tmin_ok_q && !req_i.wr) |=> (tmin_q == $past(sample_i.temp) && tmin_ok_q))
    else $error("first sample not loaded into temperature minimum");
endmodule

// ---- minmax_capture_window_regs_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module minmax_capture_window_regs_tb;
  import minmax_capture_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  reg_req_t    req;
  sample_t     smp = '0;
  logic [7:0]  rdata;
  logic        altitude_mode_select;
  logic [15:0] pwin;
  logic [7:0]  twin;
  logic [19:0] pmin, pmax;
  logic [11:0] tmin;
  logic [31:0] r, q;
  logic        mode_alt, first;
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #2.5 clk_i = ~clk_i;
  minmax_capture_window_regs u_minmax_capture_window_regs (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
    .sample_i(smp), .rdata_o(rdata), .alt_mode_o(altitude_mode_select), .press_window_o(pwin), .temp_window_o(twin));
  minmax_host_model u_minmax_host_model (.clk_i(clk_i), .req_o(req));
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      stop_test();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_minmax_host_model.xfer(1'b1, a, d);
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_minmax_host_model.xfer(1'b0, a, 8'h00);
    #1;
    `CHK(rdata, e)
  endtask
  function automatic logic lt(input logic [19:0] x, input logic [19:0] y);
    return mode_alt ? ($signed(x) < $signed(y)) : (x < y);
  endfunction
  task automatic send(input logic [19:0] p, input logic [11:0] t);
    @(posedge clk_i);
    smp <= '{valid: 1'b1, press: p, temp: t};
    @(posedge clk_i);
    smp <= '0;
    if (first || lt(p, pmin)) pmin = p;
    if (first || lt(pmax, p)) pmax = p;
    if (first || $signed(t) < $signed(tmin)) tmin = t;
    first = 1'b0;
  endtask
  task automatic cap_chk;
    rchk(8'h1C, pmin[19:12]);
    rchk(8'h1D, pmin[11:4]);
    rchk(8'h1E, {pmin[3:0], 4'h0});
    rchk(8'h21, pmax[19:12]);
    rchk(8'h22, pmax[11:4]);
    rchk(8'h23, {pmax[3:0], 4'h0});
    rchk(8'h1F, tmin[11:4]);
    rchk(8'h20, {tmin[3:0], 4'h0});
  endtask
  initial begin
    void'($urandom(32'h9b69));
    mode_alt = 1'b0;
    first = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // unmapped 1B, 24, 25 read zero alongside the reset values
    for (int a = 8'h18; a <= 8'h26; a++) rchk(8'(a), 8'h00);
    repeat (4) begin
      r = $urandom;
      wr(8'h18, r[7:0]);
      wr(8'h19, r[15:8]);
      wr(8'h1A, r[23:16]);
      `CHK(twin, r[7:0])
      `CHK(pwin, {r[15:8], r[23:16]})
      rchk(8'h1A, r[23:16]);
      rchk(8'h19, r[15:8]);
      rchk(8'h18, r[7:0]);
    end
    for (int m = 0; m < 2; m++) begin
      mode_alt = m[0];
      wr(8'h26, {mode_alt, 7'h00});
      `CHK(altitude_mode_select, mode_alt)
      // high byte last, so its zero write is the one that completes each clear
      for (int a = 8'h23; a >= 8'h1C; a--) wr(8'(a), 8'h00);
      first = 1'b1;
      pmin = '0;
      pmax = '0;
      tmin = '0;
      cap_chk();
      send(20'h80000, 12'h7FF);
      send(20'h7FFFF, 12'h800);
      repeat (20) begin
        q = $urandom;
        send(q[19:0], q[31:20]);
      end
      cap_chk();
      wr(8'h1E, 8'hFF);
      pmin[3:0] = 4'hF;
      rchk(8'h1E, 8'hF0);
    end
    stop_test();
  end
endmodule

// ---- minmax_host_model.sv ----
`timescale 1ns/1ps
module minmax_host_model
(
  input  wire logic                         clk_i,
  output minmax_capture_pkg::reg_req_t      req_o
);
  import minmax_capture_pkg::*;
  initial req_o = '0;
  // one strobe per byte, then a released cycle so strobes never merge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '0;
  endtask
endmodule
